// ==== wta_params.svh ====
`ifndef WTA_PARAMS_SVH
`define WTA_PARAMS_SVH

// control register field positions
`define WTA_IF_BIT 7
`define WTA_IE_BIT 6
`define WTA_P3_BIT 5
`define WTA_CE_BIT 4
`define WTA_RE_BIT 3
`define WTA_PLO_MSB 2
`define WTA_CTRL_W 8

// reset values
`define WTA_CTRL_RST 8'h00
`define WTA_WATCHDOG_RESET_FLAG_RST 1'b0

// time base
`define WTA_CLK_HZ 200000000
`define WTA_OSC_HZ 128000
`define WTA_OSC_DIV (`WTA_CLK_HZ / `WTA_OSC_HZ)

// time-out selection
`define WTA_BASE_TICKS 21'h000800
`define WTA_CODE_MAX 4'h9
`define WTA_CNT_W 21

// unlock window, in core clock cycles
`define WTA_UNLOCK_CYC 3'h4

`endif

// ==== wta_pkg.sv ====
package wta_pkg;

	typedef logic [7:0] wta_ctrl_t;

	typedef enum logic [2:0] {
		WTA_CMD_WRITE,
		WTA_CMD_RESTART,
		WTA_CMD_CONFIG,
		WTA_CMD_CLR_FLAG,
		WTA_CMD_ACK
	} wta_cmd_e;

	typedef enum logic [2:0] {
		WTA_ST_INIT_CLR,
		WTA_ST_UNLOCK,
		WTA_ST_APPLY,
		WTA_ST_IDLE
	} wta_host_st_e;

endpackage

// ==== wta_if.sv ====
`timescale 1ns/1ps
interface wta_if;
	logic ctrl_wr;
	logic [7:0] ctrl_wdata;
	logic [7:0] ctrl_rdata;
	logic restart;
	logic vec_ack;
	logic rsr_clr;
	logic fuse;
	logic watchdog_reset_flag;
	logic irq;
	logic sys_rst_req;

	modport dev (
		input ctrl_wr, ctrl_wdata, restart, vec_ack, rsr_clr, fuse,
		output ctrl_rdata, watchdog_reset_flag, irq, sys_rst_req
	);

	modport host (
		output ctrl_wr, ctrl_wdata, restart, vec_ack, rsr_clr, fuse,
		input ctrl_rdata, watchdog_reset_flag, irq, sys_rst_req
	);
endinterface

// ==== wta_device.sv ====
`timescale 1ns/1ps
`include "wta_params.svh"
module wta_device
	import wta_pkg::*;
#(
	parameter int unsigned OSC_DIV = `WTA_OSC_DIV
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// link to the cpu and reset logic
	wta_if.dev bus,
	// user-side status
	output logic running_o,
	output logic expire_o
);

	localparam int unsigned DIV_W = $clog2(OSC_DIV + 1);

	wta_ctrl_t ctrl;
	wta_ctrl_t next_ctrl;
	logic [2:0] win;
	logic [2:0] next_win;
	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] next_div;
	logic [`WTA_CNT_W-1:0] cnt;
	logic [`WTA_CNT_W-1:0] next_cnt;
	logic watchdog_reset_flag;
	logic next_watchdog_reset_flag;
	logic irq;
	logic next_irq;
	logic sys_rst;
	logic next_sys_rst;
	logic next_running;
	logic next_expire;

	logic tick;
	logic enabled;
	logic [3:0] code;
	logic [`WTA_CNT_W-1:0] limit;
	wta_ctrl_t w;

	// the oscillator is modelled as a tick from the core clock, so
	// everything shares one domain and nothing needs a synchroniser
	assign tick = (div == DIV_W'(OSC_DIV - 1));
	assign enabled = ctrl[`WTA_RE_BIT] | ctrl[`WTA_IE_BIT];
	assign w = bus.ctrl_wdata;

	// reserved codes fall back to the longest period so the dog still bites
	always_comb begin
		code = {ctrl[`WTA_P3_BIT], ctrl[`WTA_PLO_MSB:0]};
		if (code > `WTA_CODE_MAX) begin
			code = `WTA_CODE_MAX;
		end
		limit = `WTA_BASE_TICKS << code;
	end

	always_comb begin
		next_ctrl = ctrl;
		next_win = win;
		next_div = div;
		next_cnt = cnt;
		next_watchdog_reset_flag = watchdog_reset_flag;
		next_sys_rst = 1'b0;
		next_expire = 1'b0;

		// free-running time base
		if (tick) begin
			next_div = '0;
		end else begin
			next_div = div + DIV_W'(1);
		end

		// software writes
		if (win != 3'h0) begin
			next_win = win - 3'h1;
		end
		if (bus.ctrl_wr) begin
			if (win != 3'h0 && !w[`WTA_CE_BIT]) begin
				// timed write: reset enable and prescaler taken as given
				next_ctrl[`WTA_RE_BIT] = w[`WTA_RE_BIT];
				next_ctrl[`WTA_P3_BIT] = w[`WTA_P3_BIT];
				next_ctrl[`WTA_PLO_MSB:0] = w[`WTA_PLO_MSB:0];
				next_win = 3'h0;
			end else begin
				// plain write may only raise reset enable
				if (w[`WTA_RE_BIT]) begin
					next_ctrl[`WTA_RE_BIT] = 1'b1;
				end
				if (w[`WTA_CE_BIT] && w[`WTA_RE_BIT]) begin
					next_win = `WTA_UNLOCK_CYC;
				end
			end
			next_ctrl[`WTA_IE_BIT] = w[`WTA_IE_BIT];
			if (w[`WTA_IF_BIT]) begin
				next_ctrl[`WTA_IF_BIT] = 1'b0;
			end
		end

		// interrupt vector taken: in combined mode drop to reset mode
		if (bus.vec_ack && ctrl[`WTA_IF_BIT]) begin
			next_ctrl[`WTA_IF_BIT] = 1'b0;
			if (ctrl[`WTA_RE_BIT]) begin
				next_ctrl[`WTA_IE_BIT] = 1'b0;
			end
		end

		// counting and expiry
		if (!enabled) begin
			next_cnt = '0;
		end else if (tick) begin
			if (cnt == limit - `WTA_CNT_W'(1)) begin
				next_cnt = '0;
				next_expire = 1'b1;
				if (ctrl[`WTA_IE_BIT] &&
						!(ctrl[`WTA_RE_BIT] && ctrl[`WTA_IF_BIT])) begin
					// set wins over any clear in the same cycle
					next_ctrl[`WTA_IF_BIT] = 1'b1;
				end else begin
					next_sys_rst = 1'b1;
					next_watchdog_reset_flag = 1'b1;
				end
			end else begin
				next_cnt = cnt + `WTA_CNT_W'(1);
			end
		end
		if (bus.restart) begin
			next_cnt = '0;
		end

		// reset flag: cleared by the reset logic, set wins
		if (bus.rsr_clr && !next_sys_rst) begin
			next_watchdog_reset_flag = 1'b0;
		end

		// overrides; the control state survives the system reset it asks
		if (next_watchdog_reset_flag) begin
			next_ctrl[`WTA_RE_BIT] = 1'b1;
		end
		if (bus.fuse) begin
			next_ctrl[`WTA_RE_BIT] = 1'b1;
			next_ctrl[`WTA_IE_BIT] = 1'b0;
		end
		next_ctrl[`WTA_CE_BIT] = (next_win != 3'h0);

		next_irq = next_ctrl[`WTA_IF_BIT] & next_ctrl[`WTA_IE_BIT];
		next_running = next_ctrl[`WTA_RE_BIT] | next_ctrl[`WTA_IE_BIT];
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= `WTA_CTRL_RST;
			win <= 3'h0;
			div <= '0;
			cnt <= '0;
			watchdog_reset_flag <= `WTA_WATCHDOG_RESET_FLAG_RST;
			irq <= 1'b0;
			sys_rst <= 1'b0;
			running_o <= 1'b0;
			expire_o <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			win <= next_win;
			div <= next_div;
			cnt <= next_cnt;
			watchdog_reset_flag <= next_watchdog_reset_flag;
			irq <= next_irq;
			sys_rst <= next_sys_rst;
			running_o <= next_running;
			expire_o <= next_expire;
		end
	end

	assign bus.ctrl_rdata = ctrl;
	assign bus.watchdog_reset_flag = watchdog_reset_flag;
	assign bus.irq = irq;
	assign bus.sys_rst_req = sys_rst;

endmodule

// ==== wta_host.sv ====
`timescale 1ns/1ps
`include "wta_params.svh"
module wta_host
	import wta_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// user commands
	input wire logic cmd_valid_i,
	input wire wta_cmd_e cmd_op_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic fuse_i,
	output logic busy_o,
	// user status
	output logic [7:0] ctrl_o,
	output logic irq_o,
	output logic watchdog_reset_flag_o,
	output logic sys_rst_o,
	// link to the watchdog
	wta_if.host bus
);

	localparam wta_ctrl_t CE_M = wta_ctrl_t'(1) << `WTA_CE_BIT;
	localparam wta_ctrl_t RE_M = wta_ctrl_t'(1) << `WTA_RE_BIT;
	localparam wta_ctrl_t IF_M = wta_ctrl_t'(1) << `WTA_IF_BIT;

	wta_host_st_e st;
	wta_host_st_e next_st;
	wta_ctrl_t cfg;
	wta_ctrl_t next_cfg;
	logic wr, next_wr;
	wta_ctrl_t wdata, next_wdata;
	logic rs, next_rs;
	logic ack, next_ack;
	logic rclr, next_rclr;

	always_comb begin
		next_st = st;
		next_cfg = cfg;
		next_wr = 1'b0;
		next_wdata = wdata;
		next_rs = 1'b0;
		next_ack = 1'b0;
		next_rclr = 1'b0;
		unique case (st)
			WTA_ST_INIT_CLR: begin
				// start-up: clear the reset flag, then switch off
				next_rclr = 1'b1;
				next_cfg = `WTA_CTRL_RST;
				next_st = WTA_ST_UNLOCK;
			end
			WTA_ST_UNLOCK: begin
				// keep the old prescaler and never write one to the flag
				next_wr = 1'b1;
				next_wdata = (bus.ctrl_rdata & ~IF_M) | CE_M | RE_M;
				next_st = WTA_ST_APPLY;
			end
			WTA_ST_APPLY: begin
				next_wr = 1'b1;
				next_wdata = cfg & ~(CE_M | IF_M);
				next_st = WTA_ST_IDLE;
			end
			WTA_ST_IDLE: begin
				if (cmd_valid_i) begin
					case (cmd_op_i)
						WTA_CMD_WRITE: begin
							next_wr = 1'b1;
							next_wdata = cmd_data_i;
						end
						WTA_CMD_RESTART: begin
							next_rs = 1'b1;
						end
						WTA_CMD_CONFIG: begin
							// restart first: a shorter period could fire at once
							next_rs = 1'b1;
							next_cfg = cmd_data_i;
							next_st = WTA_ST_UNLOCK;
						end
						WTA_CMD_CLR_FLAG: begin
							next_rclr = 1'b1;
						end
						WTA_CMD_ACK: begin
							next_ack = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= WTA_ST_INIT_CLR;
			cfg <= `WTA_CTRL_RST;
			wr <= 1'b0;
			wdata <= `WTA_CTRL_RST;
			rs <= 1'b0;
			ack <= 1'b0;
			rclr <= 1'b0;
			busy_o <= 1'b1;
			ctrl_o <= `WTA_CTRL_RST;
			irq_o <= 1'b0;
			watchdog_reset_flag_o <= 1'b0;
			sys_rst_o <= 1'b0;
			bus.fuse <= 1'b0;
		end else begin
			st <= next_st;
			cfg <= next_cfg;
			wr <= next_wr;
			wdata <= next_wdata;
			rs <= next_rs;
			ack <= next_ack;
			rclr <= next_rclr;
			busy_o <= (next_st != WTA_ST_IDLE);
			ctrl_o <= bus.ctrl_rdata;
			irq_o <= bus.irq;
			watchdog_reset_flag_o <= bus.watchdog_reset_flag;
			sys_rst_o <= bus.sys_rst_req;
			bus.fuse <= fuse_i;
		end
	end

	assign bus.ctrl_wr = wr;
	assign bus.ctrl_wdata = wdata;
	assign bus.restart = rs;
	assign bus.vec_ack = ack;
	assign bus.rsr_clr = rclr;

endmodule

// ==== wta_chk.sv ====
`timescale 1ns/1ps
module wta_chk (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// link signals
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] ctrl_rdata,
	input wire logic vec_ack,
	input wire logic fuse,
	input wire logic watchdog_reset_flag,
	input wire logic sys_rst_req
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_unlock;
		ctrl_wr && ctrl_wdata[4] && ctrl_wdata[3] && !ctrl_rdata[4];
	endsequence
	// window left alone for its full length
	sequence s_quiet;
		$rose(ctrl_rdata[4]) ##0 (!ctrl_wr && ctrl_rdata[4])[*4];
	endsequence
	a_fuse_locks_mode: assert property (
		$past(fuse) && !$past(rst_i) |-> ctrl_rdata[3] && !ctrl_rdata[6])
		else $error("fuse lock lost");
	a_flag_holds_re: assert property (
		watchdog_reset_flag && $past(watchdog_reset_flag) |-> ctrl_rdata[3])
		else $error("reset enable dropped while flag set");
	a_plain_keeps_cfg: assert property (
		ctrl_wr && !ctrl_wdata[4] && !ctrl_rdata[4] |=>
		ctrl_rdata[2:0] == $past(ctrl_rdata[2:0]) &&
		ctrl_rdata[5] == $past(ctrl_rdata[5]) &&
		(ctrl_rdata[3] || !$past(ctrl_rdata[3])))
		else $error("plain write changed locked bits");
	a_unlock_opens: assert property (
		s_unlock |=> ctrl_rdata[4] && ctrl_rdata[3] &&
		ctrl_rdata[2:0] == $past(ctrl_rdata[2:0]))
		else $error("unlock write mishandled");
	a_window_closes: assert property (
		s_quiet |=> !ctrl_rdata[4])
		else $error("change window too long");
	a_apply_write: assert property (
		ctrl_wr && !ctrl_wdata[4] && ctrl_rdata[4] && !watchdog_reset_flag && !fuse
		|=> ctrl_rdata[5:0] == $past(ctrl_wdata[5:0]))
		else $error("apply write not taken");
	a_reset_pulse: assert property (
		sys_rst_req |=> !sys_rst_req && watchdog_reset_flag && ctrl_rdata[3])
		else $error("reset request shape wrong");
	a_ack_clears: assert property (
		vec_ack && ctrl_rdata[7] |=> !ctrl_rdata[7] &&
		!(ctrl_rdata[6] && $past(ctrl_rdata[3])))
		else $error("vector ack did not clear");
endmodule

// ==== test_watchdog_timer_timed_access.sv ====
`timescale 1ns/1ps
module test_watchdog_timer_timed_access import wta_pkg::*;;
	localparam int D = 2;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	wta_cmd_e cmd_op_i = WTA_CMD_WRITE;
	logic [7:0] cmd_data_i = 8'h00;
	logic fuse_i = 1'b0;
	logic busy_o, irq_o, watchdog_reset_flag_o, sys_rst_o, running_o, expire_o;
	logic [7:0] ctrl_o;
	int errors = 0;
	int cmp_count = 0;
	int rst_cnt = 0, cyc = 0, t;
	wta_if bus ();
	wta_device #(.OSC_DIV(D)) wta_device_i (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .bus(bus), .running_o(running_o),
		.expire_o(expire_o));
	wta_host wta_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
		.cmd_data_i(cmd_data_i), .fuse_i(fuse_i), .busy_o(busy_o),
		.ctrl_o(ctrl_o), .irq_o(irq_o), .watchdog_reset_flag_o(watchdog_reset_flag_o),
		.sys_rst_o(sys_rst_o), .bus(bus));
	wta_chk wta_chk_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.ctrl_wr(bus.ctrl_wr), .ctrl_wdata(bus.ctrl_wdata),
		.ctrl_rdata(bus.ctrl_rdata), .vec_ack(bus.vec_ack),
		.fuse(bus.fuse), .watchdog_reset_flag(bus.watchdog_reset_flag), .sys_rst_req(bus.sys_rst_req));
	always #2.5 core_clk_i = ~core_clk_i;
	task automatic nc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %0h got %0h", nm, e, g);
		end
	endtask
	task automatic cmd(input wta_cmd_e op, input logic [7:0] d);
		int n;
		n = 0;
		while (busy_o !== 1'b0 && n < 50) begin
			nc(1);
			n++;
		end
		cmd_valid_i = 1'b1;
		cmd_op_i = op;
		cmd_data_i = d;
		nc(1);
		cmd_valid_i = 1'b0;
		nc(4);
	endtask
	// returns cycles from the call until the next expiry pulse
	task automatic wait_exp(output int p);
		p = 1;
		nc(1);
		while (expire_o !== 1'b1 && p < 20000) begin
			nc(1);
			p++;
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// sys reset is only counted, never fed back to rst_i
	always @(posedge core_clk_i) begin
		cyc++;
		if (sys_rst_o === 1'b1) begin
			rst_cnt++;
		end
		if (cyc == 90000) begin
			errors++;
			$display("Error timeout expected 0 got 1");
			test_done();
		end
	end
	initial begin
		nc(20);
		rst_i = 1'b0;
		nc(8);
		chk("init", 10'h000, {watchdog_reset_flag_o, running_o, ctrl_o});
		$display("test init done");
		cmd(WTA_CMD_CONFIG, 8'h40);
		wait_exp(t);
		wait_exp(t);
		chk("period0", 2048 * D, t);
		nc(3);
		chk("irq", 1'b1, irq_o);
		chk("irq_rst", 0, rst_cnt);
		cmd(WTA_CMD_ACK, 8'h00);
		chk("flag", 1'b0, ctrl_o[7]);
		$display("test interrupt done");
		cmd(WTA_CMD_CONFIG, 8'h41);
		wait_exp(t);
		wait_exp(t);
		chk("period1", 4096 * D, t);
		cmd(WTA_CMD_WRITE, 8'h80);
		chk("w1c", 8'h01, ctrl_o);
		$display("test prescale done");
		cmd(WTA_CMD_CONFIG, 8'h08);
		repeat (3) begin
			nc(3000);
			cmd(WTA_CMD_RESTART, 8'h00);
		end
		chk("no_rst", 0, rst_cnt);
		wait_exp(t);
		nc(3);
		chk("rst", 1, rst_cnt);
		chk("watchdog_reset_flag", 3'b110, {watchdog_reset_flag_o, running_o, irq_o});
		cmd(WTA_CMD_CONFIG, 8'h00);
		chk("locked", 1'b1, ctrl_o[3]);
		cmd(WTA_CMD_CLR_FLAG, 8'h00);
		cmd(WTA_CMD_CONFIG, 8'h00);
		chk("off", 9'h000, {running_o, ctrl_o});
		$display("test reset done");
		cmd(WTA_CMD_CONFIG, 8'h48);
		wait_exp(t);
		nc(3);
		chk("cmb_irq", 2'b11, {irq_o, rst_cnt == 1});
		cmd(WTA_CMD_ACK, 8'h00);
		chk("cmb_ie", 2'b01, {ctrl_o[6], ctrl_o[3]});
		wait_exp(t);
		nc(3);
		chk("cmb_rst", 2, rst_cnt);
		cmd(WTA_CMD_CLR_FLAG, 8'h00);
		cmd(WTA_CMD_CONFIG, 8'h00);
		$display("test combined done");
		cmd(WTA_CMD_WRITE, 8'h07);
		chk("plain", 8'h00, ctrl_o);
		cmd(WTA_CMD_WRITE, 8'h18);
		cmd(WTA_CMD_WRITE, 8'h05);
		chk("late", 8'h08, ctrl_o);
		cmd(WTA_CMD_CONFIG, 8'h00);
		$display("test window done");
		fuse_i = 1'b1;
		cmd(WTA_CMD_CONFIG, 8'h40);
		chk("fuse", 2'b01, {ctrl_o[6], ctrl_o[3]});
		fuse_i = 1'b0;
		cmd(WTA_CMD_CONFIG, 8'h00);
		chk("unfuse", 8'h00, ctrl_o);
		$display("test fuse done");
		test_done();
	end
endmodule
